// >>> rtl/uls_top.sv
// uart receive line status flags, divisor latches, wishbone slave
// assumes one clock, rx pin asynchronous, 8 data bits, 1 stop bit
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/100ps

// Overview of operation
// [R01] parity mismatch against even select flags error
// [R02] fifo mode: parity flag follows queue head
// [R03] non-fifo: parity flag with buffer, read clears
// [R04] overrun with line irq enable raises irq
// [R05] line status read clears overrun
// [R06] non-fifo: overwrite of unread char sets overrun
// [R07] fifo mode: overrun only when full, char done
// [R08] overrun char dropped, fifo keeps its entries
// [R09] overrun visible at once, not at head
// [R10] data ready bit 0, irq with enable
// [R11] non-fifo: ready on load, cleared by read
// [R12] fifo mode: ready while queue not empty
// [R13] divisor is high latch over low latch
// [R14] divisor write stalls two wait states
// [R15] software loads both latches before use
// [R16] access select high: buffer address hits low latch
// [R17] access select low: read rx, write tx
// [R18] access select picks high latch or enables
// [R19] latches also at dedicated addresses
// [R20] queue stores parity bit per character
module uls_top
    import uls_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_i,
    output logic             irq_o,
    output logic      [7:0]  tx_data_o,
    output logic             tx_load_o
);
    logic [1:0]    rx_sync_reg;
    logic          rx_in;
    logic [7:0]    lctl_reg;
    logic [7:0]    ien_reg;
    logic [7:0]    divl_reg;
    logic [7:0]    divh_reg;
    logic [7:0]    rxb_reg;
    logic          fifo_mode_reg;
    logic          rdy_reg;
    logic          perr_reg;
    logic          oe_reg;
    logic [1:0]    wait_reg;
    logic [15:0]   baud_reg;
    logic          tick_reg;
    uls_rx_state_t st_reg;
    logic [3:0]    os_reg;
    logic [2:0]    bit_reg;
    logic [7:0]    sh_reg;
    logic          par_reg;
    logic          done_reg;
    logic          done_perr_reg;
    logic [7:0]    done_chr_reg;

    uls_tgt_t      tgt;
    logic          req;
    logic          div_wr;
    logic          go;
    logic          wr;
    logic          rd;
    logic          rd_buf;
    logic          rd_sts;
    logic          div_load;
    logic          fifo_clr;
    logic          push;
    logic          pop;
    logic [8:0]    head;
    logic          full;
    logic          empty;
    logic          rdy_flag;
    logic          perr_flag;
    logic          oe_set;
    logic [7:0]    sts_val;
    logic [7:0]    rdata;
    logic [15:0]   divisor;

    function automatic uls_tgt_t decode(input logic [7:0] adr,
                                        input logic       dsel);
        case (adr)
            OFS_BUF:  decode = dsel ? T_DIVL : T_BUF; // [R16] [R17]
            OFS_IEN:  decode = dsel ? T_DIVH : T_IEN; // [R18]
            OFS_FCR:  decode = T_FCR;
            OFS_LCTL: decode = T_LCTL;
            OFS_LSTS: decode = T_LSTS;
            OFS_DIVL: decode = T_DIVL; // [R19]
            OFS_DIVH: decode = T_DIVH; // [R19]
            default: decode = T_NONE;
        endcase
    endfunction

    // bus decode; an access completes at the edge that raises ack
    assign tgt    = decode(wb_adr_i, lctl_reg[LCTL_DSEL]);
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign div_wr = req & wb_we_i & (tgt == T_DIVL || tgt == T_DIVH);
    assign go     = req & (~div_wr | wait_reg == DIV_WAIT); // [R14]
    assign wr     = go & wb_we_i & wb_sel_i[0];
    assign rd     = go & ~wb_we_i;
    assign rd_buf = rd & (tgt == T_BUF);
    assign rd_sts = rd & (tgt == T_LSTS);
    assign div_load = wr & (tgt == T_DIVL || tgt == T_DIVH);
    assign divisor  = {divh_reg, divl_reg}; // [R13]

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_reg <= '0;
        end else if (ce) begin
            wait_reg <= (div_wr & ~go) ? wait_reg + 2'h1 : '0; // [R14]
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce) begin
            wb_ack_o <= go;
            if (go) begin
                wb_dat_o <= rd ? {24'h000000, rdata} : 32'h00000000;
            end
        end
    end

    always_comb begin
        sts_val           = 8'h00;
        sts_val[STS_RDY]  = rdy_flag; // [R10]
        sts_val[STS_OVR]  = oe_reg;
        sts_val[STS_PERR] = perr_flag;
    end

    always_comb begin
        case (tgt)
            T_BUF:   rdata = fifo_mode_reg ? head[7:0] : rxb_reg; // [R17]
            T_DIVL:  rdata = divl_reg; // [R16]
            T_DIVH:  rdata = divh_reg; // [R18]
            T_IEN:   rdata = ien_reg;
            T_FCR:   rdata = {7'h00, fifo_mode_reg};
            T_LCTL:  rdata = lctl_reg;
            T_LSTS:  rdata = sts_val;
            default: rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lctl_reg <= LCTL_RST;
        end else if (ce && wr && tgt == T_LCTL) begin
            lctl_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ien_reg <= IEN_RST;
        end else if (ce && wr && tgt == T_IEN) begin
            ien_reg <= wb_dat_i[7:0]; // [R18]
        end
    end

    // the divisor only changes at the end of the stalled write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            divl_reg <= DIVL_RST;
            divh_reg <= DIVH_RST;
        end else if (ce && wr) begin
            if (tgt == T_DIVL) begin
                divl_reg <= wb_dat_i[7:0]; // [R16] [R19]
            end
            if (tgt == T_DIVH) begin
                divh_reg <= wb_dat_i[7:0]; // [R18] [R19]
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_data_o <= TXH_RST;
            tx_load_o <= 1'b0;
        end else if (ce) begin
            tx_load_o <= wr & (tgt == T_BUF);
            if (wr && tgt == T_BUF) begin
                tx_data_o <= wb_dat_i[7:0]; // [R17]
            end
        end
    end

    // mode change also empties the queue so stale data never shows
    assign fifo_clr = wr & (tgt == T_FCR) &
                      (wb_dat_i[FCR_RXCLR] |
                       (wb_dat_i[FCR_EN] != fifo_mode_reg));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fifo_mode_reg <= 1'b0;
        end else if (ce && wr && tgt == T_FCR) begin
            fifo_mode_reg <= wb_dat_i[FCR_EN];
        end
    end

    // rx pin crosses in through two flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_sync_reg <= 2'h3;
        end else if (ce) begin
            rx_sync_reg <= {rx_sync_reg[0], rx_i};
        end
    end
    assign rx_in = rx_sync_reg[1];

    // divisor zero stops the generator; reload restarts the count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            baud_reg <= '0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            if (div_load || divisor == 16'h0000) begin
                baud_reg <= '0; // [R14]
                tick_reg <= 1'b0;
            end else if (baud_reg >= divisor - 16'h0001) begin
                baud_reg <= '0;
                tick_reg <= 1'b1;
            end else begin
                baud_reg <= baud_reg + 16'h0001;
                tick_reg <= 1'b0;
            end
        end
    end

    // 16x oversampled receiver, stop bit level is not checked
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg  <= ST_IDLE;
            os_reg  <= '0;
            bit_reg <= '0;
            sh_reg  <= '0;
            par_reg <= 1'b0;
        end else if (ce && tick_reg) begin
            os_reg <= os_reg + 4'h1;
            case (st_reg)
                ST_IDLE: begin
                    os_reg <= '0;
                    if (!rx_in) begin
                        st_reg <= ST_START;
                    end
                end
                ST_START: begin
                    if (os_reg == OVS_MID) begin
                        os_reg  <= '0;
                        bit_reg <= '0;
                        st_reg  <= rx_in ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (os_reg == OVS_LAST) begin
                        sh_reg  <= {rx_in, sh_reg[7:1]};
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == BIT_LAST) begin
                            st_reg <= lctl_reg[LCTL_PEN] ? ST_PAR : ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (os_reg == OVS_LAST) begin
                        par_reg <= rx_in;
                        st_reg  <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (os_reg == OVS_LAST) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // a finished character is a one-cycle pulse with its parity verdict
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_reg      <= 1'b0;
            done_perr_reg <= 1'b0;
            done_chr_reg  <= '0;
        end else if (ce) begin
            done_reg <= tick_reg & (st_reg == ST_STOP) &
                        (os_reg == OVS_LAST);
            if (tick_reg && st_reg == ST_STOP && os_reg == OVS_LAST) begin
                done_chr_reg  <= sh_reg;
                done_perr_reg <= lctl_reg[LCTL_PEN] &
                    ((^{sh_reg, par_reg}) == lctl_reg[LCTL_EVEN]); // [R01]
            end
        end
    end

    assign pop  = fifo_mode_reg & rd_buf & ~empty;
    assign push = fifo_mode_reg & done_reg & (~full | pop); // [R07] [R08]

    uls_rx_fifo #(
        .W     (9),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .clear (fifo_clr),
        .push  (push),
        .wdata ({done_perr_reg, done_chr_reg}), // [R20]
        .pop   (pop),
        .head  (head),
        .full  (full),
        .empty (empty)
    );

    assign rdy_flag  = fifo_mode_reg ? ~empty : rdy_reg; // [R12]
    assign perr_flag = fifo_mode_reg ? (~empty & head[8]) : perr_reg; // [R02]

    // single buffer path; a new character beats a read in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxb_reg  <= '0;
            rdy_reg  <= 1'b0;
            perr_reg <= 1'b0;
        end else if (ce) begin
            if (fifo_clr) begin
                rdy_reg  <= 1'b0;
                perr_reg <= 1'b0;
            end else if (done_reg && !fifo_mode_reg) begin
                rxb_reg  <= done_chr_reg;
                rdy_reg  <= 1'b1; // [R11]
                perr_reg <= done_perr_reg; // [R03]
            end else if (rd_buf && !fifo_mode_reg) begin
                rdy_reg  <= 1'b0; // [R11]
                perr_reg <= 1'b0; // [R03]
            end
        end
    end

    // a read in the same cycle as the arrival saves the old char
    assign oe_set = done_reg & (fifo_mode_reg ? (full & ~pop) // [R07]
                                              : (rdy_reg & ~rd_buf)); // [R06]

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oe_reg <= 1'b0;
        end else if (ce) begin
            oe_reg <= oe_set | (oe_reg & ~rd_sts); // [R05] [R09]
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_o <= 1'b0;
        end else if (ce) begin
            irq_o <= (ien_reg[IEN_LSI] & (oe_reg | perr_flag)) | // [R04]
                     (ien_reg[IEN_RXI] & rdy_flag); // [R10]
        end
    end
endmodule

// >>> rtl/uls_pkg.sv
// constants and types for the receive line status and divisor block
// assumes a 32-bit classic wishbone slave with byte addresses
package uls_pkg;
    localparam int          ADR_W      = 8;
    // register byte offsets
    localparam logic [7:0]  OFS_BUF    = 8'h00;
    localparam logic [7:0]  OFS_IEN    = 8'h04;
    localparam logic [7:0]  OFS_FCR    = 8'h08;
    localparam logic [7:0]  OFS_LCTL   = 8'h0C;
    localparam logic [7:0]  OFS_LSTS   = 8'h14;
    localparam logic [7:0]  OFS_DIVL   = 8'h20;
    localparam logic [7:0]  OFS_DIVH   = 8'h24;
    // field positions
    localparam int          STS_RDY    = 0;
    localparam int          STS_OVR    = 1;
    localparam int          STS_PERR   = 2;
    localparam int          IEN_RXI    = 0;
    localparam int          IEN_LSI    = 2;
    localparam int          LCTL_PEN   = 3;
    localparam int          LCTL_EVEN  = 4;
    localparam int          LCTL_DSEL  = 7;
    localparam int          FCR_EN     = 0;
    localparam int          FCR_RXCLR  = 1;
    // reset values
    localparam logic [7:0]  LCTL_RST   = 8'h00;
    localparam logic [7:0]  IEN_RST    = 8'h00;
    localparam logic [7:0]  DIVL_RST   = 8'h00;
    localparam logic [7:0]  DIVH_RST   = 8'h00;
    localparam logic [7:0]  TXH_RST    = 8'h00;
    // timing counts
    localparam logic [1:0]  DIV_WAIT   = 2'h2;
    localparam logic [3:0]  OVS_MID    = 4'h7;
    localparam logic [3:0]  OVS_LAST   = 4'hF;
    localparam logic [2:0]  BIT_LAST   = 3'h7;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_START = 5'b00010,
        ST_DATA  = 5'b00100,
        ST_PAR   = 5'b01000,
        ST_STOP  = 5'b10000
    } uls_rx_state_t;

    typedef enum logic [2:0] {
        T_NONE, T_BUF, T_DIVL, T_IEN, T_DIVH, T_FCR, T_LCTL, T_LSTS
    } uls_tgt_t;
endpackage

// >>> rtl/uls_rx_fifo.sv
// receive queue: character plus its error bit per entry
// assumes depth is a power of two; head comes out of a register
`timescale 1ns/100ps
module uls_rx_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire logic         clear,
    input  wire logic         push,
    input  wire logic [W-1:0] wdata,
    input  wire logic         pop,
    output logic      [W-1:0] head,
    output logic              full,
    output logic              empty
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW-1:0] rd_next;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;
    logic          do_push;
    logic          do_pop;

    // push while full only succeeds when a pop frees a slot
    assign do_pop   = pop & ~empty;
    assign do_push  = push & (~full | do_pop);
    assign rd_next  = do_pop ? rd_reg + 1'b1 : rd_reg;
    assign cnt_next = cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);

    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem[wr_reg] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (ce) begin
            if (clear) begin
                wr_reg  <= '0;
                rd_reg  <= '0;
                cnt_reg <= '0;
            end else begin
                wr_reg  <= do_push ? wr_reg + 1'b1 : wr_reg;
                rd_reg  <= rd_next;
                cnt_reg <= cnt_next;
            end
        end
    end

    // bypass: the word being written may become the new head
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            head <= '0;
        end else if (ce) begin
            if (do_push && wr_reg == rd_next) begin
                head <= wdata;
            end else begin
                head <= mem[rd_next];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            full  <= 1'b0;
            empty <= 1'b1;
        end else if (ce) begin
            full  <= ~clear & (cnt_next == (AW+1)'(DEPTH));
            empty <= clear | (cnt_next == '0);
        end
    end
endmodule

// >>> dv/uls_top_monitor.sv
// bus timing checks on the line status and divisor block
// assumes ce held high; sees only the top module's ports
`timescale 1ns/100ps
module uls_top_monitor
    import uls_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tx_load_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // a request is first seen when cyc and stb are first both high
    sequence s_req_rise;
        $rose(wb_cyc_i && wb_stb_i);
    endsequence
    sequence s_two_wait;
        !wb_ack_o [*2] ##1 wb_ack_o;
    endsequence

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

    property p_divl_wait;
        s_req_rise ##0 (wb_we_i && wb_adr_i == OFS_DIVL) |=> s_two_wait;
    endproperty
    a_divl_wait: assert property (p_divl_wait)
        else $error("low latch write without two wait states");

    property p_divh_wait;
        s_req_rise ##0 (wb_we_i && wb_adr_i == OFS_DIVH) |=> s_two_wait;
    endproperty
    a_divh_wait: assert property (p_divh_wait)
        else $error("high latch write without two wait states");

    // status read: prompt answer, only the three low flag bits live
    property p_sts_read;
        s_req_rise ##0 (!wb_we_i && wb_adr_i == OFS_LSTS)
            |=> wb_ack_o && wb_dat_o[31:3] == 29'h0;
    endproperty
    a_sts_read: assert property (p_sts_read)
        else $error("line status read late or upper bits set");

    // selecting the latches must not itself stall the bus
    property p_lctl_fast;
        s_req_rise ##0 (wb_we_i && wb_adr_i == OFS_LCTL) |=> wb_ack_o;
    endproperty
    a_lctl_fast: assert property (p_lctl_fast)
        else $error("line control write stalled");

    property p_tx_cause;
        tx_load_o |-> wb_ack_o && wb_we_i && wb_adr_i == OFS_BUF;
    endproperty
    a_tx_cause: assert property (p_tx_cause)
        else $error("tx load without buffer write");

    property p_tx_pulse;
        tx_load_o |=> !tx_load_o;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("tx load wider than one cycle");

    property p_ded_no_tx;
        wb_ack_o && wb_we_i && (wb_adr_i == OFS_DIVL || wb_adr_i == OFS_DIVH)
            |-> !tx_load_o;
    endproperty
    a_ded_no_tx: assert property (p_ded_no_tx)
        else $error("dedicated latch write loaded tx");
endmodule

// >>> dv/uls_ser_tx.sv
// remote serial transmitter driving the receive line
// assumes 8 data bits, optional parity, one stop bit, lsb first
`timescale 1ns/100ps
module uls_ser_tx #(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk,
    output logic      rx_o
);
    // line idles at mark level between frames
    initial rx_o = 1'b1;

    task automatic send(input logic [7:0] d, input logic pen,
                        input logic even, input logic bad);
        logic [10:0] f;
        int          n;
        n = pen ? 11 : 10;
        // bad flips the parity bit to provoke an error on purpose
        f = {1'b1, (even ? ^d : ~^d) ^ bad, d, 1'b0};
        if (!pen) begin
            f[9] = 1'b1;
        end
        for (int i = 0; i < n; i++) begin
            rx_o <= f[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        rx_o <= 1'b1;
    endtask
endmodule

// >>> dv/tb_uls_top.sv
// bench for line status flags and divisor latches over wishbone
// assumes divisor 1, so one serial bit lasts 16 clock cycles
`timescale 1ns/100ps
module tb_uls_top;
    import uls_pkg::*;
    localparam int FIFO_DEPTH = 4;
    logic        clk      = 1'b0;
    logic        reset    = 1'b1;
    logic        ce       = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        rx_i;
    logic        irq_o;
    logic [7:0]  tx_data_o;
    logic        tx_load_o;
    logic [31:0] rd;
    logic [7:0]  lctl;
    int          failures = 0;
    int          checked  = 0;

    always #5 clk = ~clk;

    uls_top #(.FIFO_DEPTH(FIFO_DEPTH)) i_uls_top (
        .clk(clk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_i(rx_i), .irq_o(irq_o),
        .tx_data_o(tx_data_o), .tx_load_o(tx_load_o));
    uls_ser_tx #(.BIT_CYC(16)) i_uls_ser_tx (.clk(clk), .rx_o(rx_i));

    task automatic final_report();
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] a,
                           input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            failures++;
            final_report();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb_xfer(1'b1, a, {24'h0, d});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    // margin covers the two-flop synchroniser and flag update
    task automatic send_char(input logic [7:0] d, input logic bad);
        i_uls_ser_tx.send(d, 1'b1, lctl[LCTL_EVEN], bad);
        repeat (8) @(posedge clk);
    endtask

    initial begin
        lctl = 8'h00;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdchk(OFS_DIVL, {24'h0, DIVL_RST});
        rdchk(OFS_DIVH, {24'h0, DIVH_RST});
        rdchk(OFS_LSTS, 32'h00);
        rdchk(8'h40, 32'h00);
        wr(OFS_LCTL, 8'h80);
        wr(OFS_BUF, 8'hA5);
        wr(OFS_IEN, 8'h3C);
        rdchk(OFS_DIVL, 32'hA5);
        rdchk(OFS_DIVH, 32'h3C);
        rdchk(OFS_BUF, 32'hA5);
        rdchk(OFS_IEN, 32'h3C);
        wr(OFS_LCTL, 8'h00);
        rdchk(OFS_IEN, {24'h0, IEN_RST});
        wr(OFS_DIVH, 8'h00);
        wr(OFS_DIVL, 8'h01);
        rdchk(OFS_DIVH, 32'h00);
        wr(OFS_BUF, 8'h5A);
        check({24'h0, tx_data_o}, 32'h5A);
        rdchk(OFS_DIVL, 32'h01);
        // both parity senses, a clean then a corrupted character
        for (int k = 0; k < 2; k++) begin
            lctl = (k == 0) ? 8'h18 : 8'h08;
            wr(OFS_LCTL, lctl);
            send_char(8'h33, 1'b0);
            rdchk(OFS_LSTS, 32'h01);
            rdchk(OFS_BUF, 32'h33);
            send_char(8'h55, 1'b1);
            rdchk(OFS_LSTS, 32'h05);
            rdchk(OFS_BUF, 32'h55);
            rdchk(OFS_LSTS, 32'h00);
        end
        wr(OFS_IEN, 8'h01);
        send_char(8'h11, 1'b0);
        check({31'h0, irq_o}, 32'h1);
        send_char(8'h22, 1'b0);
        wr(OFS_IEN, 8'h04);
        repeat (2) @(posedge clk);
        check({31'h0, irq_o}, 32'h1);
        rdchk(OFS_LSTS, 32'h03);
        repeat (2) @(posedge clk);
        check({31'h0, irq_o}, 32'h0);
        rdchk(OFS_BUF, 32'h22);
        rdchk(OFS_LSTS, 32'h00);
        wr(OFS_IEN, 8'h00);
        // queue mode: fill to the brim, then one character too many
        wr(OFS_FCR, 8'h01);
        for (int k = 0; k <= FIFO_DEPTH; k++) begin
            send_char(8'(8'h40 + k), 1'(k == 0));
            if (k == FIFO_DEPTH - 1) begin
                rdchk(OFS_LSTS, 32'h05);
            end
        end
        rdchk(OFS_LSTS, 32'h07);
        for (int k = 0; k < FIFO_DEPTH; k++) begin
            rdchk(OFS_BUF, 32'(8'h40 + k));
            if (k == 0) begin
                rdchk(OFS_LSTS, 32'h01);
            end
        end
        rdchk(OFS_LSTS, 32'h00);
        // queue flush command empties the queue but keeps the mode
        send_char(8'h66, 1'b0);
        rdchk(OFS_LSTS, 32'h01);
        wr(OFS_FCR, 8'h03);
        rdchk(OFS_LSTS, 32'h00);
        rdchk(OFS_FCR, 32'h01);
        final_report();
    end
endmodule

bind uls_top uls_top_monitor i_uls_top_monitor (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_load_o(tx_load_o));
